// ---- logic/sfc_adc_frame.sv ----
// Purpose: Frame, conversion and serial result control of a dual-input
//          12-bit successive-approximation converter.
// Assumes: The host drives frame select and channel pick in step with the
//          link clock; link clock may stop outside frames.
// Notes: Analog inputs are 16-bit fractions of the supply; results also
//        leave on a buffered word stream in the system clock domain.

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - First link clock falling edge samples chosen input, starts conversion, opens frame.
// - Result output changes only on link clock falling edges; select rising also clears dout_o to 0.
// - Channel pick high converts input two, low converts input one.
// - Frame carries leading zero, 12 result bits MSB first, two zeros.
// - Exactly one binary-weighted result bit resolved per link clock cycle.
// - MSB shown in 2nd cycle, LSB in 13th cycle.
// - Normal frame releases result output during the 16th cycle.
// - Straight binary coding, transitions midway between integer LSB values.
// - Select low at 10th falling edge commits frame to normal completion.
// - Select rising before 10th falling edge aborts and powers down.
// - Dummy frame output is invalid; the following frame is valid.
// - Wake-up time equals dummy frame length, 333ns at 48MHz.
// - Full 3Msps only at 48MHz link clock; slower clock, slower rate.
// - Fourteen-cycle frames allowed; output then never released by count.
module sfc_adc_frame (
  // System clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic input_channel_pick_i,
  output logic dout_o,
  output logic dout_oe_o,
  // Analog input stand-ins
  input wire logic [15:0] analog_input_one_i,
  input wire logic [15:0] analog_input_two_i,
  // Result stream
  output logic result_valid_o,
  input wire logic result_ready_i,
  output logic [11:0] result_code_o,
  output logic result_channel_o,
  // Status
  output logic overrun_o,
  output logic asleep_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Bit weight of the result bit resolved at a given falling edge

  function automatic logic [11:0] sfc_weight(input logic [4:0] cnt);
    logic [11:0] w;
    w = 12'h000;
    if (cnt <= sfc_pkg::FALL_LSB) begin
      w = sfc_pkg::TOP_WEIGHT >> cnt[3:0];
    end
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Link domain state

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic hiz_reg;
  logic dout_reg;
  logic dout_next;
  logic [15:0] sample_reg;
  logic chan_reg;
  logic [11:0] code_reg;
  logic [11:0] code_next;
  logic open_reg;
  logic commit_reg;
  sfc_pkg::sfc_link_state_t state_reg;
  sfc_pkg::sfc_link_state_t frame_state;
  sfc_pkg::sfc_word_t xfer_reg;
  logic xfer_tgl_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Link domain decode

  wire frame_low = ~cs_n_i;
  wire first_fall = (cnt_reg == sfc_pkg::FALL_MSB);
  wire resolving = (cnt_reg <= sfc_pkg::FALL_LSB);
  wire at_commit = (cnt_reg == sfc_pkg::FALL_COMMIT);
  wire at_lsb = (cnt_reg == sfc_pkg::FALL_LSB);
  wire at_release = (cnt_reg == sfc_pkg::FALL_HIZ);

  // Input mux ahead of the sample-and-hold
  wire [15:0] live_level = input_channel_pick_i ? analog_input_two_i
                                                : analog_input_one_i;

  // First decision uses the live level, later ones the held sample
  wire [15:0] cmp_level = first_fall ? live_level : sample_reg;

  // Half-LSB offset places code edges midway between integer LSBs
  wire [16:0] cmp_adj = {1'b0, cmp_level} + sfc_pkg::HALF_LSB;

  wire [11:0] code_base = first_fall ? sfc_pkg::CODE_RESET : code_reg;
  wire [11:0] trial = code_base | sfc_weight(cnt_reg);
  wire bit_set = (cmp_adj >= {1'b0, trial, 4'h0});

  assign code_next = bit_set ? trial : code_base;

  // Previous frame opened but never reached its commit edge
  wire prev_aborted = open_reg & ~commit_reg;

  assign frame_state = !first_fall ? state_reg :
                       prev_aborted ? sfc_pkg::SFC_DUMMY : sfc_pkg::SFC_ACTIVE;

  // Leading zero before edge 1, bits after edges 1..12, zeros after
  assign dout_next = resolving & bit_set
                     & (frame_state == sfc_pkg::SFC_ACTIVE);

  // Counter stops at its ceiling so a delayed restart stays released
  assign cnt_next = (cnt_reg == sfc_pkg::CNT_SAT) ? cnt_reg
                                                  : cnt_reg + 5'h01;

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: frame counter and pin drive, cleared by select high

  always_ff @(negedge sclk_i or posedge cs_n_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= sfc_pkg::CNT_RESET;
      dout_reg <= 1'b0;
      hiz_reg <= 1'b0;
    end else if (cs_n_i) begin
      cnt_reg <= sfc_pkg::CNT_RESET;
      dout_reg <= 1'b0;
      hiz_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      dout_reg <= dout_next;
      if (at_release) begin
        hiz_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: conversion, mode tracking and word hand-off

  always_ff @(negedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sample_reg <= sfc_pkg::SAMPLE_RESET;
      chan_reg <= 1'b0;
      code_reg <= sfc_pkg::CODE_RESET;
      open_reg <= 1'b0;
      commit_reg <= 1'b0;
      state_reg <= sfc_pkg::SFC_ACTIVE;
      xfer_reg <= '0;
      xfer_tgl_reg <= 1'b0;
    end else if (frame_low) begin
      if (first_fall) begin
        sample_reg <= live_level;
        chan_reg <= input_channel_pick_i;
        open_reg <= 1'b1;
        commit_reg <= 1'b0;
        state_reg <= frame_state;
      end
      if (resolving) begin
        code_reg <= code_next;
      end
      if (at_commit) begin
        commit_reg <= 1'b1;
      end
      if (at_lsb && state_reg == sfc_pkg::SFC_ACTIVE) begin
        xfer_reg <= '{channel: chan_reg, code: code_next};
        xfer_tgl_reg <= ~xfer_tgl_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin drive

  assign dout_o = dout_reg;

  // Released while select high, after edge 15, or after an abort
  assign dout_oe_o = frame_low & ~hiz_reg;

  // Asleep from an abort until the dummy frame's first edge
  wire asleep_lk = prev_aborted & (cs_n_i | first_fall);

  //////////////////////////////////////////////////////////////////////////////
  // System domain crossings

  logic [2:0] tgl_sync_reg;
  logic [1:0] sleep_sync_reg;
  logic overrun_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tgl_sync_reg <= sfc_pkg::SYNC_RESET;
      sleep_sync_reg <= 2'h0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], xfer_tgl_reg};
      sleep_sync_reg <= {sleep_sync_reg[0], asleep_lk};
    end
  end

  // Word is stable for a whole frame after its toggle, so it is read here
  wire word_arrive = tgl_sync_reg[2] ^ tgl_sync_reg[1];

  //////////////////////////////////////////////////////////////////////////////
  // Result buffer

  sfc_stream_if in_if ();
  sfc_stream_if out_if ();

  assign in_if.valid = word_arrive;
  assign in_if.data = xfer_reg;
  assign out_if.ready = result_ready_i;

  sfc_buf u_buf (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_s(in_if),
    .out_s(out_if)
  );

  // Host cannot be stalled; a word meeting a full buffer is flagged
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overrun_reg <= 1'b0;
    end else begin
      overrun_reg <= word_arrive & ~in_if.ready;
    end
  end

  assign result_valid_o = out_if.valid;
  assign result_code_o = out_if.data.code;
  assign result_channel_o = out_if.data.channel;
  assign overrun_o = overrun_reg;
  assign asleep_o = sleep_sync_reg[1];

endmodule

// ---- inc/sfc_pkg.sv ----
// Purpose: Shared constants and types of the serial frame converter control.
// Assumes: Link counter counts falling link clock edges since the frame opened.
// Notes: Analog levels are modelled as 16-bit fractions of the supply.
package sfc_pkg;
  // Resolution, analog stand-in and counter widths, buffer depth, sync length
  localparam int RES_W = 12;
  localparam int ANA_W = 16;
  localparam int CNT_W = 5;
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_LEN = 3;
  // Falling-edge counter values, taken before the edge is counted
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam logic [4:0] FALL_MSB = 5'h00;
  localparam logic [4:0] FALL_COMMIT = 5'h09;
  localparam logic [4:0] FALL_LSB = 5'h0b;
  localparam logic [4:0] FALL_HIZ = 5'h0e;
  localparam logic [4:0] CNT_SAT = 5'h0f;
  // Half an LSB in analog stand-in units (one LSB is 16 units)
  localparam logic [16:0] HALF_LSB = 17'h00008;
  localparam logic [11:0] TOP_WEIGHT = 12'h800;
  // Reset values
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [15:0] SAMPLE_RESET = 16'h0000;
  localparam logic [1:0] COUNT_RESET = 2'h0;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  // Frame timing figures
  localparam int FRAME_CYCLES = 16;
  localparam int SHORT_FRAME_CYCLES = 14;
  localparam int WAKE_FALLS = 10;
  localparam int LINK_FULL_MHZ = 48;
  localparam int WAKE_TIME_NS = 333;
  localparam int FULL_RATE_KSPS = LINK_FULL_MHZ * 1000 / FRAME_CYCLES;
  localparam int WAKE_CYCLES_FULL = (WAKE_TIME_NS * LINK_FULL_MHZ) / 1000;
  localparam int SYS_CLK_MHZ = 20;

  typedef enum logic {
    SFC_ACTIVE,
    SFC_DUMMY
  } sfc_link_state_t;

  typedef struct packed {
    logic channel;
    logic [11:0] code;
  } sfc_word_t;
endpackage

// ---- inc/sfc_stream_if.sv ----
// Purpose: Valid/ready word stream between converter control and its buffer.
// Assumes: Both ends on the system clock.
// Notes: Data is stable while valid is high and ready is low.
interface sfc_stream_if;
  logic valid;
  logic ready;
  sfc_pkg::sfc_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- logic/sfc_buf.sv ----
// Purpose: Two-entry word buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Output data comes straight from the storage flops.
module sfc_buf (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Streams
  sfc_stream_if.snk in_s,
  sfc_stream_if.src out_s
);
  sfc_pkg::sfc_word_t mem_reg [sfc_pkg::BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  wire push = in_s.valid & in_s.ready;
  wire pop = out_s.valid & out_s.ready;

  assign in_s.ready = (count_reg != 2'(sfc_pkg::BUF_DEPTH));
  assign out_s.valid = (count_reg != sfc_pkg::COUNT_RESET);
  assign out_s.data = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= sfc_pkg::COUNT_RESET;
    end else begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg <= count_reg + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_s.data;
    end
  end
endmodule

// ---- verification/sfc_frame_sva.sv ----
// Purpose: Port-level checks of the serial frame converter control.
// Assumes: Link clock idles high; frame counter mirrors falls with select low.
// Notes: Bound to the top module; sees its ports only.
module sfc_frame_sva (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  // Link and status
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic overrun_o,
  input wire logic asleep_o
);
  logic [4:0] fall_cnt;
  logic dout_rise;
  logic low_rise;

  // Falls seen in the open frame, cleared while select is high
  always_ff @(negedge sclk_i or posedge cs_n_i or negedge reset_n_i) begin
    if (!reset_n_i) fall_cnt <= 5'h00;
    else if (cs_n_i) fall_cnt <= 5'h00;
    else if (fall_cnt != 5'h1f) fall_cnt <= fall_cnt + 5'h01;
  end

  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dout_rise <= 1'b0;
      low_rise <= 1'b0;
    end else begin
      dout_rise <= dout_o;
      low_rise <= !cs_n_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_oe_idle;
    @(posedge clk_i) disable iff (!reset_n_i) cs_n_i |-> !dout_oe_o && !dout_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while idle");
  property p_lead;
    @(posedge clk_i) disable iff (!reset_n_i)
      !cs_n_i && fall_cnt == 5'h00 |-> dout_oe_o && !dout_o;
  endproperty
  a_lead: assert property (p_lead) else $error("no leading zero at frame open");
  property p_drive;
    @(posedge sclk_i) disable iff (!reset_n_i)
      !cs_n_i && fall_cnt inside {[5'h01:5'h0c]} |-> dout_oe_o;
  endproperty
  a_drive: assert property (p_drive) else $error("result bit not driven");
  property p_trail;
    @(posedge sclk_i) disable iff (!reset_n_i)
      !cs_n_i && fall_cnt inside {5'h0d, 5'h0e} |-> dout_oe_o && !dout_o;
  endproperty
  a_trail: assert property (p_trail) else $error("trailing zero wrong");
  property p_hiz;
    @(posedge sclk_i) disable iff (!reset_n_i) !cs_n_i && fall_cnt >= 5'h0f |-> !dout_oe_o;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output not released in cycle 16");
  property p_on_fall;
    @(negedge sclk_i) disable iff (!reset_n_i)
      !cs_n_i && low_rise && fall_cnt != 5'h00 |-> dout_o == dout_rise;
  endproperty
  a_on_fall: assert property (p_on_fall) else $error("output moved off a fall");
  property p_sleep;
    @(posedge clk_i) disable iff (!reset_n_i) $rose(asleep_o) |-> cs_n_i;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entered inside a frame");
  property p_short;
    @(posedge sclk_i) disable iff (!reset_n_i)
      !cs_n_i && fall_cnt == 5'h0e ##1 !cs_n_i |-> fall_cnt == 5'h0f || dout_oe_o;
  endproperty
  a_short: assert property (p_short) else $error("released before cycle 16");

  c_full: cover property (@(posedge sclk_i) disable iff (!reset_n_i) fall_cnt == 5'h0f);
  c_abort: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(asleep_o));
  c_ovr: cover property (@(posedge clk_i) disable iff (!reset_n_i) overrun_o);
endmodule

bind sfc_adc_frame sfc_frame_sva u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .sclk_i(sclk_i), .cs_n_i(cs_n_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
  .overrun_o(overrun_o), .asleep_o(asleep_o));

// ---- verification/sfc_host_model.sv ----
// Purpose: Serial host that frames conversions and samples the result line.
// Assumes: Link clock idles high and stands still between frames.
// Notes: A released line is captured as z so a stale bit never passes.
module sfc_host_model (
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic pick_o,
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] bits;

  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    pick_o = 1'b0;
  end

  // Bit 15 is the opening bit, bit 15-k the bit after fall k
  task automatic frame(input int falls, input logic pick, input int half);
    bits = 'x;
    pick_o = pick;
    #7;
    cs_n_o = 1'b0;
    #8;
    bits[15] = dout_oe_i ? dout_i : 1'bz;
    for (int k = 1; k <= falls; k++) begin
      sclk_o = 1'b0;
      #(half);
      sclk_o = 1'b1;
      if (k <= 15) bits[15-k] = dout_oe_i ? dout_i : 1'bz;
      #(half);
    end
    cs_n_o = 1'b1;
    #30;
  endtask
endmodule

// ---- verification/test_sar_adc_serial_frame_control.sv ----
// Purpose: Self-checking bench of the serial frame converter control.
// Assumes: Host model frames conversions; bench feeds levels and drains words.
// Notes: Expected codes are round-half-up of level over sixteen.
module test_sar_adc_serial_frame_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, reset_n_i, sclk_i, cs_n_i, pick, dout_o, dout_oe_o, stall;
  logic result_valid_o, result_ready_i, result_channel_o, overrun_o, asleep_o;
  logic [15:0] analog_input_one, analog_input_two;
  logic [11:0] result_code_o;
  logic [12:0] exp_q[$];
  int failures = 0, checks = 0, cycles = 0, ovrs = 0, base, seed;
  logic [15:0] corners [6] = '{16'h0000, 16'h0007, 16'h0008, 16'h7ff7, 16'hfff7, 16'hffff};

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  sfc_adc_frame uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .input_channel_pick_i(pick), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
    .analog_input_one_i(analog_input_one), .analog_input_two_i(analog_input_two), .result_valid_o(result_valid_o),
    .result_ready_i(result_ready_i), .result_code_o(result_code_o),
    .result_channel_o(result_channel_o), .overrun_o(overrun_o), .asleep_o(asleep_o));
  sfc_host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .pick_o(pick), .dout_i(dout_o),
    .dout_oe_i(dout_oe_o));

  function automatic logic [11:0] exp_code(input logic [15:0] lvl);
    logic [16:0] s;
    s = {1'b0, lvl} + 17'h00008;
    exp_code = s[16] ? 12'hfff : s[15:4];
  endfunction

  task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t serial frame %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One frame; the other input carries the inverse level
  task automatic run(input int falls, input logic push, input logic ch, input logic [15:0] lvl,
      input int half);
    logic [11:0] c;
    c = exp_code(lvl);
    analog_input_one <= ch ? ~lvl : lvl;
    analog_input_two <= ch ? lvl : ~lvl;
    @(posedge clk_i);
    if (push) exp_q.push_back({ch, c});
    host.frame(falls, ch, half);
    if (falls >= 14) chk_bits(host.bits, {1'b0, c, 2'b00, falls >= 15 ? 1'bz : 1'bx});
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic drain;
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk_i);
    chk_flag(exp_q.size() == 0, 1'b1);
  endtask

  always @(posedge clk_i) begin
    result_ready_i <= stall ? 1'b0 : 1'(($random(seed) & 3) != 0);
    cycles++;
    if (cycles == 4000) begin
      failures++;
      $display("ERROR %0t timeout", $time);
      wrap_up;
    end
  end

  always @(negedge clk_i) begin
    if (overrun_o === 1'b1) ovrs++;
    if (result_valid_o === 1'b1 && result_ready_i === 1'b1)
      chk_word({result_channel_o, result_code_o},
        exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  end

  initial begin
    seed = 32'h10050583;
    reset_n_i = 1'b0;
    stall = 1'b0;
    analog_input_one = 16'h0000;
    analog_input_two = 16'h0000;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    chk_flag(asleep_o, 1'b0);
    for (int i = 0; i < 6; i++) run(15, 1'b1, 1'(i), corners[i], 15);
    for (int i = 0; i < 8; i++) run(15, 1'b1, 1'($random(seed)), 16'($random(seed)), 15);
    run(14, 1'b1, 1'b0, 16'($random(seed)), 15);
    run(15, 1'b1, 1'b1, 16'($random(seed)), 40);
    run(10, 1'b0, 1'b0, 16'($random(seed)), 15);
    chk_flag(asleep_o, 1'b0);
    run(5, 1'b0, 1'b1, 16'($random(seed)), 15);
    chk_flag(asleep_o, 1'b1);
    run(12, 1'b0, 1'b0, 16'hffff, 15);
    chk_bits({host.bits[15:3], 3'h0}, 16'h0000);
    chk_flag(asleep_o, 1'b0);
    run(15, 1'b1, 1'b1, 16'($random(seed)), 15);
    drain();
    stall <= 1'b1;
    base = ovrs;
    for (int i = 0; i < 3; i++) run(15, i < 2, 1'($random(seed)), 16'($random(seed)), 15);
    chk_flag(ovrs == base + 1, 1'b1);
    stall <= 1'b0;
    drain();
    wrap_up;
  end
endmodule
